// ### hdl/sas_defines.vh
// constants for the successive-approximation converter sequencer
`ifndef SAS_DEFINES_VH
`define SAS_DEFINES_VH
`define SAS_ADDR_CTRL 8'hd8
`define SAS_ADDR_RESULT 8'hd9
`define SAS_ADDR_REFPROG 8'hda
`define SAS_CTRL_RESET 8'h00
`define SAS_RESULT_RESET 8'h00
`define SAS_REFPROG_RESET 8'h00
`define SAS_CTRL_CHAN_LSB 0
`define SAS_CTRL_CHAN_MSB 2
`define SAS_CTRL_CONT_BIT 3
`define SAS_CTRL_BUSY_BIT 4
`define SAS_CTRL_DONE_BIT 5
`define SAS_REF_LOW_LSB 0
`define SAS_REF_LOW_MSB 3
`define SAS_REF_HIGH_LSB 4
`define SAS_REF_HIGH_MSB 7
`define SAS_CONV_CYCLES 15
`define SAS_SAMPLE_CYCLES 7
`define SAS_STEPS 8
`endif

// ### hdl/sas_ref_decode.v
// maps a 4-bit reference selection to an 8-bit fraction of the external span
`timescale 1ns/1ns
module sas_ref_decode (
  // selection
  input wire [3:0] sel_i,
  input wire high_i,
  // level as fraction of span, 8'hff meaning full
  output wire [7:0] level_o
);
  // zero selection yields the external reference itself
  assign level_o = (sel_i == 4'h0) ? (high_i ? 8'hff : 8'h00) : {sel_i, 4'h0};
endmodule

// ### hdl/sas_sar_step.v
// one trial of the approximation register
`timescale 1ns/1ns
module sas_sar_step (
  // state
  input wire [7:0] code_i,
  input wire [2:0] bit_i,
  input wire keep_i,
  // next code
  output reg [7:0] code_o
);
  reg [7:0] one;
  integer k;
  always @* begin
    one = 8'h00;
    for (k = 0; k < 8; k = k + 1) begin
      if (k == bit_i) begin
        one[k] = 1'b1;
      end
    end
    code_o = code_i;
    if (!keep_i) begin
      code_o = code_i & ~one;
    end
    if (bit_i != 3'd0) begin
      code_o = code_o | (one >> 1);
    end
  end
endmodule

// ### hdl/sas_top.v
// sequencer of the 8-bit successive-approximation converter
// Notes on behaviour
// - result is unsigned code 00 to ff
// - first trial compares held input with half
// - later trials keep bits, add next weight
// - exactly eight trials, msb first
// - duration fixed, independent of input
// - input sampled each of seven sampling cycles, held whole conversion
// - low and high references from sixteen steps
// - selection zero gives external references
// - reference program write stores and starts
// - writing zero converts with external references
// - write during conversion restarts from start
// - result register written at completion
// - result register is plain storage otherwise
// - conversion takes fifteen machine cycles
// - one of eight channels via multiplexer
// - continuous mode repeats on same channel
`timescale 1ns/1ns
`include "sas_defines.vh"
module sas_top (
  // clock and reset
  input wire clk_i,
  input wire rstn_i,
  // special function register port
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  output reg [7:0] sfr_rdata_o,
  // analog side, digitised channels and comparator
  input wire [63:0] chan_level_i,
  input wire cmp_above_i,
  output reg [2:0] mux_sel_o,
  output reg sample_o,
  output reg [7:0] trial_o,
  output reg [7:0] internal_low_reference_o,
  output reg [7:0] internal_high_reference_o,
  output reg [7:0] held_level_o,
  // status
  output reg busy_o,
  output reg done_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SAMPLE = 2'd1;
  localparam ST_CONV = 2'd2;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] converter_control_r;
  reg [7:0] conversion_result_r;
  reg [7:0] reference_program_start_r;
  reg [3:0] cnt_r;
  reg [2:0] bit_r;
  reg [7:0] code_r;
  reg cont_r;
  wire wr_ctrl;
  wire wr_res;
  wire wr_ref;
  wire [7:0] low_lvl;
  wire [7:0] high_lvl;
  wire [7:0] next_code;
  wire last_step;
  wire above;
  assign wr_ctrl = sfr_wr_i && (sfr_addr_i == `SAS_ADDR_CTRL);
  assign wr_res = sfr_wr_i && (sfr_addr_i == `SAS_ADDR_RESULT);
  assign wr_ref = sfr_wr_i && (sfr_addr_i == `SAS_ADDR_REFPROG);
  assign last_step = (state_r == ST_CONV) && (cnt_r == 4'd`SAS_CONV_CYCLES - 4'd1);
  // comparator is sampled at the last cycle of each trial
  assign above = cmp_above_i;

  ////////////////////////////////////////////////////////////////////////
  // reference selection decode
  sas_ref_decode u_low (
    .sel_i(reference_program_start_r[`SAS_REF_LOW_MSB:`SAS_REF_LOW_LSB]),
    .high_i(1'b0),
    .level_o(low_lvl)
  );
  sas_ref_decode u_high (
    .sel_i(reference_program_start_r[`SAS_REF_HIGH_MSB:`SAS_REF_HIGH_LSB]),
    .high_i(1'b1),
    .level_o(high_lvl)
  );

  sas_sar_step u_step (
    .code_i(code_r),
    .bit_i(bit_r),
    .keep_i(above),
    .code_o(next_code)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequence control
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        state_nxt = ST_IDLE;
      end
      ST_SAMPLE: begin
        if (cnt_r == 4'd`SAS_SAMPLE_CYCLES - 4'd1) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (last_step) begin
          state_nxt = cont_r ? ST_SAMPLE : ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (wr_ref) begin
      state_nxt = ST_SAMPLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state and step counter
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      // fixed count, no early exit on any input value
      if (wr_ref || last_step) begin
        cnt_r <= 4'h0;
      end else if (state_r != ST_IDLE) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      converter_control_r <= `SAS_CTRL_RESET;
      reference_program_start_r <= `SAS_REFPROG_RESET;
    end else begin
      if (wr_ctrl) begin
        converter_control_r <= sfr_wdata_i;
      end
      if (wr_ref) begin
        reference_program_start_r <= sfr_wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel and mode taken at start
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cont_r <= 1'b0;
      mux_sel_o <= 3'h0;
    end else begin
      if (wr_ref) begin
        cont_r <= converter_control_r[`SAS_CTRL_CONT_BIT];
        mux_sel_o <= converter_control_r[`SAS_CTRL_CHAN_MSB:`SAS_CTRL_CHAN_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded references
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      internal_low_reference_o <= 8'h00;
      internal_high_reference_o <= 8'hff;
    end else begin
      internal_low_reference_o <= low_lvl;
      internal_high_reference_o <= high_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sampling and busy indication
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sample_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      sample_o <= (state_nxt == ST_SAMPLE);
      busy_o <= (state_nxt != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // hold and approximation register
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      held_level_o <= 8'h00;
      bit_r <= 3'h7;
      code_r <= 8'h80;
      trial_o <= 8'h80;
    end else begin
      if (state_r == ST_SAMPLE) begin
        // loaded on every sampling cycle, comparator never sees the live channel afterwards
        held_level_o <= chan_level_i[mux_sel_o*8 +: 8];
      end
      if (wr_ref || state_r == ST_SAMPLE) begin
        // a start or restart always opens with the half-span trial
        bit_r <= 3'h7;
        code_r <= 8'h80;
        trial_o <= 8'h80;
      end else if (state_r == ST_CONV && !last_step) begin
        // one trial per cycle, the last bit resolves at the final cycle
        code_r <= next_code;
        trial_o <= next_code;
        bit_r <= bit_r - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result register and completion flag
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conversion_result_r <= `SAS_RESULT_RESET;
      done_o <= 1'b0;
    end else begin
      if (last_step && !wr_ref) begin
        conversion_result_r <= above ? code_r : (code_r & 8'hfe);
        done_o <= 1'b1;
      end else if (wr_res) begin
        conversion_result_r <= sfr_wdata_i;
      end
      if (wr_ref) begin
        done_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      case (sfr_addr_i)
        `SAS_ADDR_CTRL: begin
          sfr_rdata_o <= {converter_control_r[7:6], done_o, busy_o, converter_control_r[3:0]};
        end
        `SAS_ADDR_RESULT: begin
          sfr_rdata_o <= conversion_result_r;
        end
        `SAS_ADDR_REFPROG: begin
          sfr_rdata_o <= reference_program_start_r;
        end
        default: begin
          sfr_rdata_o <= 8'h00;
        end
      endcase
    end
  end
endmodule

// ### testbench/sas_top_properties.sv
// port assertions of the converter sequencer
`timescale 1ns/1ns
module sas_top_chk (
  // clock and reset
  input wire clk_i,
  input wire rstn_i,
  // register port and status
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire [2:0] mux_sel_o,
  input wire sample_o,
  input wire [7:0] trial_o,
  input wire [7:0] internal_low_reference_o,
  input wire [7:0] internal_high_reference_o,
  input wire [7:0] held_level_o,
  input wire busy_o,
  input wire done_o
);
  wire st = sfr_wr_i && sfr_addr_i == 8'hda;
  reg [5:0] cnt_r;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      cnt_r <= 6'h3f;
    else if (st)
      cnt_r <= 6'h00;
    else if (cnt_r != 6'h3f)
      cnt_r <= cnt_r + 6'h01;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_start; st |=> busy_o && !done_o; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_sample; st |=> sample_o; endproperty
  a_sample: assert property (p_sample) else $error("no sampling");
  property p_msb; st |=> trial_o == 8'h80; endproperty
  a_msb: assert property (p_msb) else $error("bad first trial");
  property p_ext; st && sfr_wdata_i == 8'h00 |-> ##[1:2] internal_low_reference_o == 8'h00
    && internal_high_reference_o == 8'hff; endproperty
  a_ext: assert property (p_ext) else $error("bad references");
  property p_time; $rose(done_o) |-> cnt_r == 6'h0f; endproperty
  a_time: assert property (p_time) else $error("bad duration");
  property p_hold; busy_o && !sample_o && $past(busy_o) && !$past(sample_o) |-> $stable(held_level_o);
  endproperty
  a_hold: assert property (p_hold) else $error("held level moved");
  property p_mux; busy_o && $past(busy_o) && !$past(st) |-> $stable(mux_sel_o); endproperty
  a_mux: assert property (p_mux) else $error("channel moved");
  property p_busy; st |=> busy_o [*8]; endproperty
  a_busy: assert property (p_busy) else $error("busy dropped");
endmodule
bind sas_top sas_top_chk chk_i (.clk_i, .rstn_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .mux_sel_o, .sample_o,
  .trial_o, .internal_low_reference_o, .internal_high_reference_o, .held_level_o, .busy_o, .done_o);

// ### testbench/sas_cmp_model.sv
// comparator model of the analog front end
`timescale 1ns/1ns
module sas_cmp_model (
  // held level and trial code
  input wire [7:0] held_i,
  input wire [7:0] trial_i,
  // decision
  output wire above_o
);
  assign above_o = held_i >= trial_i;
endmodule

// ### testbench/sas_top_tb.sv
// self-checking bench of the converter sequencer
`timescale 1ns/1ns
`include "sas_defines.vh"
module sas_top_tb;
  reg clk_i = 1'b0, rstn_i = 1'b0, wr = 1'b0, rd = 1'b0;
  reg [7:0] adr = 8'h00, wd = 8'h00, d;
  reg [63:0] lv = 64'haa55fe017f80ff00;
  reg [63:0] ch = 64'haa55fe017f80ff00;
  wire [7:0] rdat, trl, hld, lo, hi;
  wire [2:0] mx;
  wire cmp, busy, done;
  int n_fail = 0, compares = 0, n;
  always #25 clk_i = ~clk_i;
  sas_cmp_model cm (.held_i(hld), .trial_i(trl), .above_o(cmp));
  sas_top uut (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(adr), .sfr_wdata_i(wd), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_rdata_o(rdat), .chan_level_i(ch), .cmp_above_i(cmp), .mux_sel_o(mx), .sample_o(),
    .trial_o(trl), .internal_low_reference_o(lo), .internal_high_reference_o(hi), .held_level_o(hld),
    .busy_o(busy), .done_o(done));
  task chk(input string nm, input [7:0] e, input [7:0] g);
    compares++;
    if (g !== e) begin
      $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task wrt(input [7:0] a, input [7:0] v);
    @(posedge clk_i);
    adr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task rdr(input [7:0] a);
    @(posedge clk_i);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  task conv(input [7:0] rp);
    wrt(8'hda, rp);
    #1 n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(posedge clk_i);
      if (n == 10)
        ch <= ~lv;
      #1 n++;
    end
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    rdr(8'hd9);
    chk("result reset", `SAS_RESULT_RESET, d);
    rdr(8'hd8);
    chk("control reset", `SAS_CTRL_RESET, d);
    wrt(8'hd9, 8'h5a);
    rdr(8'hd9);
    chk("result storage", 8'h5a, d);
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_i);
      ch <= lv;
      wrt(8'hd8, c[7:0]);
      conv(8'h00);
      chk("duration", 8'(`SAS_CONV_CYCLES), n[7:0]);
      rdr(8'hd9);
      chk("result", lv[8*c+:8], d);
      rdr(8'hd8);
      chk("status", {2'b10, 1'b0, c[2:0]}, {2'b00, d[5:0]});
    end
    $display("test channels done");
    @(posedge clk_i);
    ch <= lv;
    wrt(8'hda, 8'h00);
    repeat (12) @(posedge clk_i);
    conv(8'h00);
    chk("restart duration", 8'(`SAS_CONV_CYCLES), n[7:0]);
    rdr(8'hd9);
    chk("restart result", lv[63:56], d);
    chk("external low", 8'h00, lo);
    chk("external high", 8'hff, hi);
    conv(8'h31);
    chk("reference duration", 8'(`SAS_CONV_CYCLES), n[7:0]);
    chk("internal low", 8'h10, lo);
    chk("internal high", 8'h30, hi);
    $display("test restart done");
    wrt(8'hd8, 8'h0a);
    conv(8'h00);
    @(posedge clk_i);
    ch <= lv;
    repeat (60) @(posedge clk_i);
    #1 chk("continuous busy", 8'h01, {7'h00, busy});
    chk("channel", 8'h02, {5'h00, mx});
    rdr(8'hd9);
    chk("continuous result", lv[23:16], d);
    $display("test continuous done");
    end_sim;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    end_sim;
  end
endmodule
